/* design/mcs_defs.vh */
// Constants for the memory self-test block: CRC settings, commands,
// controller states, march phases and buffer sizing.
// Assumes inclusion by its bare name from the design file.
`ifndef MCS_DEFS_VH
`define MCS_DEFS_VH

`define MCS_CRC_POLY 32'h1EDC6F41
`define MCS_CRC_INIT 32'hFFFFFFFF
`define MCS_CRC_XOROUT 32'hFFFFFFFF
`define MCS_ONES 32'hFFFFFFFF
`define MCS_ZEROS 32'h00000000

`define MCS_OP_INIT 3'h0
`define MCS_OP_START 3'h1
`define MCS_OP_ADD 3'h2
`define MCS_OP_RESULT 3'h3
`define MCS_OP_CALC 3'h4
`define MCS_OP_VERIFY 3'h5
`define MCS_OP_MARCH 3'h6

`define MCS_ST_IDLE 3'h0
`define MCS_ST_CRC 3'h1
`define MCS_ST_REF 3'h2
`define MCS_ST_MARCH 3'h3
`define MCS_ST_COPY 3'h4
`define MCS_ST_FIN 3'h5

`define MCS_PH_BUF 2'h0
`define MCS_PH_SAVE 2'h1
`define MCS_PH_AREA 2'h2
`define MCS_PH_REST 2'h3

// Element field positions
`define MCS_EL_LAST 5
`define MCS_EL_DOWN 4
`define MCS_EL_RD 3
`define MCS_EL_RDONE 2
`define MCS_EL_WR 1
`define MCS_EL_WRONE 0

`define MCS_FIFO_DEPTH 16
`define MCS_FIFO_AW 4
`define MCS_LAST_NIB 3'h7

`endif

/* design/mcs_top.v */
// Memory self-test block: CRC-32C signature engine and March C/X RAM engine,
// plus the read-data FIFO between the memory port and the CRC engine.
// Assumes one clock, commands from logic on the same clock, and a memory
// that answers each request with a one-cycle i_mem_ack.
`timescale 1ns/10ps
`include "mcs_defs.vh"
`default_nettype none

module mcs_fifo #(
  parameter W = 32,
  parameter D = `MCS_FIFO_DEPTH,
  parameter AW = `MCS_FIFO_AW
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg [W-1:0] mem_ff [0:D-1];
  reg [AW-1:0] wp_ff;
  reg [AW-1:0] rp_ff;
  reg [AW:0] cnt_ff;
  localparam [AW:0] FULL = D;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;
  assign o_in_ready = (cnt_ff != FULL);
  assign o_out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign o_out_data = mem_ff[rp_ff];
  always @(posedge i_clk)
  begin
    if (push)
    begin
      mem_ff[wp_ff] <= i_in_data;
    end
  end
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wp_ff <= {AW{1'b0}};
      rp_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop)
      begin
        rp_ff <= rp_ff + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_ff <= cnt_ff + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // mcs_fifo

module mcs_top (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_start,
  input wire [2:0] i_op,
  input wire [31:0] i_addr_lo,
  input wire [31:0] i_addr_hi,
  input wire [31:0] i_ref_addr,
  input wire [31:0] i_buf_addr,
  input wire i_nondestr,
  input wire i_buf_check,
  input wire i_march_x,
  input wire [31:0] i_mem_rdata,
  input wire i_mem_ack,
  output reg o_busy,
  output reg o_done,
  output reg o_pass,
  output reg [31:0] o_sig,
  output reg o_mem_req,
  output reg o_mem_we,
  output reg [31:0] o_mem_addr,
  output reg [31:0] o_mem_wdata
);
  reg [2:0] st_ff;
  reg [2:0] op_ff;
  reg [1:0] ph_ff;
  reg [2:0] elem_ff;
  reg wrop_ff;
  reg fail_ff;
  reg xmode_ff;
  reg nd_ff;
  reg [2:0] nib_ff;
  reg [31:0] crc_ff;
  reg [31:0] rd_addr_ff;
  reg [31:0] rd_end_ff;
  reg [31:0] addr_ff;
  reg [31:0] lo_ff;
  reg [31:0] hi_ff;
  reg [31:0] idx_ff;
  reg [31:0] hold_ff;
  reg [31:0] area_lo_ff;
  reg [31:0] area_hi_ff;
  reg [31:0] buf_ff;

  // four message bits per call, MSB first
  function [31:0] mcs_crc4(input [31:0] c, input [3:0] d);
    integer k;
    reg fb;
    begin
      mcs_crc4 = c;
      fb = 1'h0;
      for (k = 3; k >= 0; k = k - 1)
      begin
        fb = mcs_crc4[31] ^ d[k];
        mcs_crc4 = {mcs_crc4[30:0], 1'h0} ^ (fb ? `MCS_CRC_POLY : `MCS_ZEROS);
      end
    end
  endfunction

  // element table {last, down, rd, rd_one, wr, wr_one}
  function [5:0] mcs_elem(input x, input [2:0] e);
    begin
      case ({x, e})
        4'h0: mcs_elem = 6'h02;
        4'h1: mcs_elem = 6'h0B;
        4'h2: mcs_elem = 6'h0E;
        4'h3: mcs_elem = 6'h1B;
        4'h4: mcs_elem = 6'h1E;
        4'h5: mcs_elem = 6'h28;
        4'h8: mcs_elem = 6'h02;
        4'h9: mcs_elem = 6'h0B;
        4'hA: mcs_elem = 6'h1E;
        default: mcs_elem = 6'h28;
      endcase
    end
  endfunction

  wire [5:0] el = mcs_elem(xmode_ff, elem_ff);
  wire [5:0] el_n = mcs_elem(xmode_ff, elem_ff + 3'h1);
  wire [31:0] rd_pat = el[`MCS_EL_RDONE] ? `MCS_ONES : `MCS_ZEROS;
  wire [31:0] wr_pat = el[`MCS_EL_WRONE] ? `MCS_ONES : `MCS_ZEROS;
  wire at_end = el[`MCS_EL_DOWN] ? (addr_ff == lo_ff) : (addr_ff == hi_ff);
  wire [31:0] span = area_hi_ff - area_lo_ff;
  wire [31:0] copy_src = (ph_ff == `MCS_PH_SAVE) ? area_lo_ff : buf_ff;
  wire [31:0] copy_dst = (ph_ff == `MCS_PH_SAVE) ? buf_ff : area_lo_ff;
  wire [31:0] sig = crc_ff ^ `MCS_CRC_XOROUT;
  wire f_in_ready;
  wire f_out_valid;
  wire [31:0] f_out_data;
  wire f_in_valid = (st_ff == `MCS_ST_CRC) && i_mem_ack;
  wire f_out_ready = (st_ff == `MCS_ST_CRC) && (nib_ff == `MCS_LAST_NIB);
  wire [31:0] f_sh = f_out_data << {nib_ff, 2'h0};

  mcs_fifo #(.W(32), .D(`MCS_FIFO_DEPTH), .AW(`MCS_FIFO_AW)) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(f_in_valid),
    .o_in_ready(f_in_ready),
    .i_in_data(i_mem_rdata),
    .o_out_valid(f_out_valid),
    .i_out_ready(f_out_ready),
    .o_out_data(f_out_data)
  );

  task finish(input ok);
    begin
      // done pulse with result, busy drops
      o_busy <= 1'h0;
      o_done <= 1'h1;
      o_pass <= ok;
      st_ff <= `MCS_ST_IDLE;
    end
  endtask

  task issue(input we, input [31:0] a, input [31:0] d);
    begin
      o_mem_req <= 1'h1;
      o_mem_we <= we;
      o_mem_addr <= a;
      o_mem_wdata <= d;
    end
  endtask

  task march_begin(input [31:0] lo, input [31:0] hi);
    begin
      lo_ff <= lo;
      hi_ff <= hi;
      addr_ff <= lo;
      elem_ff <= 3'h0;
      wrop_ff <= 1'h1;
      st_ff <= `MCS_ST_MARCH;
    end
  endtask

  task copy_begin(input [1:0] ph);
    begin
      ph_ff <= ph;
      idx_ff <= `MCS_ZEROS;
      wrop_ff <= 1'h0;
      st_ff <= `MCS_ST_COPY;
    end
  endtask

  task march_end(input fl);
    begin
      if (ph_ff == `MCS_PH_BUF)
      begin
        // buffer fault aborts before any copy
        if (fl)
          finish(1'h0);
        else
          copy_begin(`MCS_PH_SAVE);
      end
      else if (nd_ff)
        // restore area after test, pass or fail
        copy_begin(`MCS_PH_REST);
      else
        finish(!fl);
    end
  endtask

  task advance;
    begin
      // next cell only after all ops on this one
      if (at_end)
      begin
        if (el[`MCS_EL_LAST])
          march_end(fail_ff);
        else
        begin
          elem_ff <= elem_ff + 3'h1;
          wrop_ff <= !el_n[`MCS_EL_RD];
          addr_ff <= el_n[`MCS_EL_DOWN] ? hi_ff : lo_ff;
        end
      end
      else
      begin
        wrop_ff <= !el[`MCS_EL_RD];
        addr_ff <= el[`MCS_EL_DOWN] ? addr_ff - 32'h1 : addr_ff + 32'h1;
      end
    end
  endtask

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_busy <= 1'h0;
      o_done <= 1'h0;
      o_pass <= 1'h0;
      o_sig <= `MCS_ZEROS;
      o_mem_req <= 1'h0;
      o_mem_we <= 1'h0;
      o_mem_addr <= `MCS_ZEROS;
      o_mem_wdata <= `MCS_ZEROS;
      st_ff <= `MCS_ST_IDLE;
      op_ff <= `MCS_OP_INIT;
      ph_ff <= `MCS_PH_AREA;
      elem_ff <= 3'h0;
      wrop_ff <= 1'h0;
      fail_ff <= 1'h0;
      xmode_ff <= 1'h0;
      nd_ff <= 1'h0;
      nib_ff <= 3'h0;
      crc_ff <= `MCS_CRC_INIT;
      rd_addr_ff <= `MCS_ZEROS;
      rd_end_ff <= `MCS_ZEROS;
      addr_ff <= `MCS_ZEROS;
      lo_ff <= `MCS_ZEROS;
      hi_ff <= `MCS_ZEROS;
      idx_ff <= `MCS_ZEROS;
      hold_ff <= `MCS_ZEROS;
      area_lo_ff <= `MCS_ZEROS;
      area_hi_ff <= `MCS_ZEROS;
      buf_ff <= `MCS_ZEROS;
    end
    else
    begin
      o_done <= 1'h0;
      if (i_mem_ack)
        o_mem_req <= 1'h0;
      case (st_ff)
        `MCS_ST_IDLE:
        begin
          if (i_start)
          begin
            o_busy <= 1'h1;
            op_ff <= i_op;
            fail_ff <= 1'h0;
            nib_ff <= 3'h0;
            // word range from start address and length
            rd_addr_ff <= i_addr_lo;
            rd_end_ff <= i_addr_lo + i_addr_hi;
            st_ff <= `MCS_ST_FIN;
            case (i_op)
              `MCS_OP_INIT, `MCS_OP_START:
                crc_ff <= `MCS_CRC_INIT;
              `MCS_OP_ADD:
                st_ff <= `MCS_ST_CRC;
              // result over all ranges since start
              `MCS_OP_RESULT:
                o_sig <= sig;
              `MCS_OP_CALC, `MCS_OP_VERIFY:
              begin
                crc_ff <= `MCS_CRC_INIT;
                st_ff <= `MCS_ST_CRC;
              end
              `MCS_OP_MARCH:
              begin
                xmode_ff <= i_march_x;
                nd_ff <= i_nondestr;
                area_lo_ff <= i_addr_lo;
                area_hi_ff <= i_addr_hi;
                buf_ff <= i_buf_addr;
                // end below start is a failure
                if (i_addr_hi < i_addr_lo)
                  fail_ff <= 1'h1;
                else if (i_nondestr && i_buf_check)
                begin
                  ph_ff <= `MCS_PH_BUF;
                  march_begin(i_buf_addr, i_buf_addr + (i_addr_hi - i_addr_lo));
                end
                else if (i_nondestr)
                  copy_begin(`MCS_PH_SAVE);
                else
                begin
                  ph_ff <= `MCS_PH_AREA;
                  march_begin(i_addr_lo, i_addr_hi);
                end
              end
              default:
                fail_ff <= 1'h1;
            endcase
          end
        end
        `MCS_ST_FIN:
          finish(!fail_ff);
        `MCS_ST_CRC:
        begin
          if (!o_mem_req && (rd_addr_ff != rd_end_ff) && f_in_ready)
          begin
            issue(1'h0, rd_addr_ff, `MCS_ZEROS);
            rd_addr_ff <= rd_addr_ff + 32'h1;
          end
          if (f_out_valid)
          begin
            // nibble-serial division, eight cycles per word
            crc_ff <= mcs_crc4(crc_ff, f_sh[31:28]);
            nib_ff <= nib_ff + 3'h1;
          end
          else if (!o_mem_req && (rd_addr_ff == rd_end_ff))
          begin
            if (op_ff == `MCS_OP_ADD)
              finish(1'h1);
            else if (op_ff == `MCS_OP_CALC)
            begin
              o_sig <= sig;
              finish(1'h1);
            end
            else
            begin
              o_sig <= sig;
              st_ff <= `MCS_ST_REF;
            end
          end
        end
        `MCS_ST_REF:
        begin
          // pass only on equal reference word
          // compare fresh signature to stored one
          if (i_mem_ack)
            finish(i_mem_rdata == sig);
          else if (!o_mem_req)
            issue(1'h0, i_ref_addr, `MCS_ZEROS);
        end
        `MCS_ST_MARCH:
        begin
          if (i_mem_ack)
          begin
            if (!wrop_ff)
            begin
              // mismatch sets sticky fail, ends march
              if (i_mem_rdata != rd_pat)
              begin
                fail_ff <= 1'h1;
                march_end(1'h1);
              end
              else if (el[`MCS_EL_WR])
                wrop_ff <= 1'h1;
              else
                advance;
            end
            else
              advance;
          end
          else if (!o_mem_req)
            issue(wrop_ff, addr_ff, wr_pat);
        end
        `MCS_ST_COPY:
        begin
          if (i_mem_ack)
          begin
            if (!wrop_ff)
            begin
              hold_ff <= i_mem_rdata;
              wrop_ff <= 1'h1;
            end
            else if (idx_ff == span)
            begin
              if (ph_ff == `MCS_PH_SAVE)
              begin
                ph_ff <= `MCS_PH_AREA;
                march_begin(area_lo_ff, area_hi_ff);
              end
              else
                finish(!fail_ff);
            end
            else
            begin
              idx_ff <= idx_ff + 32'h1;
              wrop_ff <= 1'h0;
            end
          end
          else if (!o_mem_req)
          begin
            if (wrop_ff)
              issue(1'h1, copy_dst + idx_ff, hold_ff);
            else
              issue(1'h0, copy_src + idx_ff, `MCS_ZEROS);
          end
        end
        default:
          st_ff <= `MCS_ST_IDLE;
      endcase
    end
  end
endmodule // mcs_top
`default_nettype wire

/* verif/mcs_mem_model.sv */
// Word memory standing on the memory port of mcs_top: 64 words,
// set answer latency, optional single-bit read fault at one address.
// Assumes one outstanding request, held until the answer.
`timescale 1ns/10ps
`default_nettype none
module mcs_mem_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_lat,
  input wire logic [5:0] i_fault_addr,
  input wire logic i_fault_en,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [0:63];
  logic [3:0] wait_ff;
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ack <= 1'b0;
      wait_ff <= 4'h0;
      o_rdata <= 32'h0;
    end
    else if (o_ack || !i_req)
    begin
      o_ack <= 1'b0;
      wait_ff <= 4'h0;
      o_rdata <= ~o_rdata;
    end
    else if (wait_ff < i_lat)
    begin
      wait_ff <= wait_ff + 4'h1;
      o_rdata <= ~o_rdata;
    end
    else
    begin
      o_ack <= 1'b1;
      if (i_we)
        mem[i_addr[5:0]] <= i_wdata;
      else
        o_rdata <= mem[i_addr[5:0]] ^ {31'h0, i_fault_en && i_addr[5:0] == i_fault_addr};
    end
  end
endmodule // mcs_mem_model
`default_nettype wire

/* verif/mcs_top_sva.sv */
// Port checker for mcs_top: command handshake and memory port timing.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/10ps
`include "mcs_defs.vh"
`default_nettype none
module mcs_top_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [2:0] i_op,
  input wire logic [31:0] i_addr_lo,
  input wire logic [31:0] i_addr_hi,
  input wire logic i_mem_ack,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_pass,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [31:0] o_mem_addr,
  input wire logic [31:0] o_mem_wdata
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  wire take = i_start && !o_busy && !o_done;
  // Two-cycle command with no memory traffic
  sequence s_short;
    o_busy && !o_mem_req ##1 o_done && !o_busy;
  endsequence
  a_busy_on_take: assert property (take |=> o_busy)
    else $error("busy not raised after accepted command");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_done_ends_busy: assert property (o_done |-> !o_busy && $past(o_busy))
    else $error("done without preceding busy");
  a_pass_held: assert property (!o_done |-> $stable(o_pass))
    else $error("pass changed outside done");
  a_short_cmd: assert property (take && (i_op == `MCS_OP_INIT || i_op == `MCS_OP_START ||
    i_op == `MCS_OP_RESULT) |=> s_short)
    else $error("short command timing wrong");
  a_bad_range: assert property (take && i_op == `MCS_OP_MARCH && i_addr_hi < i_addr_lo
    |=> s_short ##0 !o_pass)
    else $error("reversed range not refused");
  a_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr)
    && $stable(o_mem_we) && $stable(o_mem_wdata))
    else $error("memory request changed before answer");
  a_req_drop: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
    else $error("request held after answer");
  a_idle_no_mem: assert property (!o_busy |-> !o_mem_req)
    else $error("memory request while idle");
endmodule // mcs_top_chk
bind mcs_top mcs_top_chk chk_u (.i_clk, .i_rst_n, .i_start, .i_op, .i_addr_lo, .i_addr_hi, .i_mem_ack,
  .o_busy, .o_done, .o_pass, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata);
`default_nettype wire

/* verif/mcs_top_bench.sv */
// Self-checking bench for mcs_top: command table, then multi-range,
// refused start, non-destructive and fault cases.
// Assumes mcs_mem_model on the memory port and a 10 MHz clock.
`timescale 1ns/10ps
`include "mcs_defs.vh"
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module mcs_top_bench;
  typedef struct {logic [2:0] op; int lo; int hi; int rf; logic [2:0] f; logic [3:0] lt; logic cp; logic ep;
    logic cs;} mcs_row_t;
  logic i_clk = 1'b0;
  logic i_rst_n, i_start, i_nondestr, i_buf_check, i_march_x, i_mem_ack, o_busy, o_done, o_pass, o_mem_req;
  logic o_mem_we, fault_en;
  logic [2:0] i_op;
  logic [31:0] i_addr_lo, i_addr_hi, i_ref_addr, i_buf_addr, i_mem_rdata, o_sig, o_mem_addr, o_mem_wdata;
  logic [31:0] exp_sig;
  logic [3:0] lat;
  logic [5:0] fault_addr;
  logic [64:0] trc[$];
  logic [64:0] exq[$];
  int error_cnt = 0;
  int samples_checked = 0;
  int hits;
  mcs_row_t rows[10] = '{'{0, 0, 0, 0, 0, 0, 0, 0, 0}, '{4, 0, 4, 0, 0, 0, 0, 0, 1}, '{4, 0, 24, 0, 0, 0, 0, 0, 1},
    '{4, 5, 3, 0, 0, 2, 0, 0, 1}, '{5, 0, 4, 34, 0, 1, 1, 1, 1}, '{5, 0, 4, 35, 0, 0, 1, 0, 1},
    '{6, 48, 50, 0, 0, 0, 1, 1, 0}, '{6, 48, 50, 0, 1, 1, 1, 1, 0}, '{6, 50, 48, 0, 0, 0, 1, 0, 0},
    '{7, 0, 0, 0, 0, 0, 1, 0, 0}};

  mcs_top dut_u (.i_clk, .i_rst_n, .i_start, .i_op, .i_addr_lo, .i_addr_hi, .i_ref_addr, .i_buf_addr,
    .i_nondestr, .i_buf_check, .i_march_x, .i_mem_rdata, .i_mem_ack, .o_busy, .o_done, .o_pass, .o_sig,
    .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata);
  mcs_mem_model mem_u (.i_clk, .i_rst_n, .i_req(o_mem_req), .i_we(o_mem_we), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .i_lat(lat), .i_fault_addr(fault_addr), .i_fault_en(fault_en), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata));

  always #50 i_clk = ~i_clk;
  always @(posedge i_clk)
    if (o_mem_req && i_mem_ack)
      trc.push_back({o_mem_we, o_mem_addr, o_mem_we ? o_mem_wdata : 32'h0});

  function automatic logic [31:0] pat(input int i);
    return 32'h9E3779B9 * (i + 1);
  endfunction
  // Serial MSB-first update, one bit at a time
  function automatic logic [31:0] crc_add(input logic [31:0] c, input int a, input int n);
    logic [31:0] d;
    for (int k = 0; k < n; k++)
    begin
      d = pat(a + k);
      for (int b = 31; b >= 0; b--)
        c = {c[30:0], 1'b0} ^ ((c[31] ^ d[b]) ? 32'h1EDC6F41 : 32'h0);
    end
    return c;
  endfunction
  // Element nibbles: descending, read, write, value
  task automatic gen_march(input int lo, input int hi, input logic x);
    logic [23:0] el;
    logic [3:0] e;
    int a;
    el = x ? 24'h27E400 : 24'h276FE4;
    for (int j = 0; j < (x ? 4 : 6); j++)
    begin
      e = el[23 - 4 * j -: 4];
      for (int i = 0; i <= hi - lo; i++)
      begin
        a = e[3] ? hi - i : lo + i;
        if (e[2])
          exq.push_back({1'b0, 32'(a), 32'h0});
        if (e[1])
          exq.push_back({1'b1, 32'(a), {32{e[0]}}});
      end
    end
  endtask
  task automatic gen_copy(input int s, input int d);
    for (int i = 0; i < 2; i++)
    begin
      exq.push_back({1'b0, 32'(s + i), 32'h0});
      exq.push_back({1'b1, 32'(d + i), pat(48 + i)});
    end
  endtask
  task automatic chk_trace();
    `CHK("trace length", exq.size(), trc.size())
    for (int i = 0; i < exq.size() && i < trc.size(); i++)
      `CHK("trace entry", exq[i], trc[i])
    exq.delete();
  endtask
  task automatic tally_and_finish();
    $display("checked %0d wrong %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic run(input logic [2:0] op, input int lo, input int hi, input int rf, input logic [2:0] f);
    int n;
    n = 0;
    trc.delete();
    @(posedge i_clk);
    i_op <= op;
    i_addr_lo <= lo;
    i_addr_hi <= hi;
    i_ref_addr <= rf;
    {i_nondestr, i_buf_check, i_march_x} <= f;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    #1;
    while (o_done !== 1'b1 && n < 4000)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n == 4000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic nd_case(input logic f);
    for (int i = 0; i < 2; i++)
      mem_u.mem[48 + i] = pat(48 + i);
    fault_en = f;
    gen_march(56, 57, 1'b0);
    gen_copy(48, 56);
    gen_march(48, 49, 1'b0);
    gen_copy(56, 48);
    run(6, 48, 49, 0, 3'b110);
    `CHK("nondestructive pass", ~f, o_pass)
    if (f)
    begin
      hits = 0;
      foreach (trc[i])
        if (trc[i][63:32] < 32'd56)
          hits++;
      `CHK("area accesses", 0, hits)
      exq.delete();
    end
    else
      chk_trace();
    for (int i = 0; i < 2; i++)
      `CHK("restored word", pat(48 + i), mem_u.mem[48 + i])
    $display("nondestructive case fault=%0d done", f);
  endtask

  initial
  begin
    i_rst_n = 1'b0;
    {i_start, i_nondestr, i_buf_check, i_march_x, fault_en} = 5'h00;
    {i_op, i_addr_lo, i_addr_hi, i_ref_addr} = 99'h0;
    i_buf_addr = 32'd56;
    lat = 4'h0;
    fault_addr = 6'd57;
    for (int i = 0; i < 64; i++)
      mem_u.mem[i] = pat(i);
    mem_u.mem[34] = ~crc_add(32'hFFFFFFFF, 0, 4);
    mem_u.mem[35] = 32'h0;
    repeat (2) @(posedge i_clk);
    #1 `CHK("reset outputs", 36'h0, {o_busy, o_done, o_pass, o_mem_req, o_sig})
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    foreach (rows[r])
    begin
      lat = rows[r].lt;
      exp_sig = ~crc_add(32'hFFFFFFFF, rows[r].lo, rows[r].hi);
      if (rows[r].op == `MCS_OP_MARCH)
        gen_march(rows[r].lo, rows[r].hi, rows[r].f[0]);
      run(rows[r].op, rows[r].lo, rows[r].hi, rows[r].rf, rows[r].f);
      if (rows[r].cs)
        `CHK("signature", exp_sig, o_sig)
      if (rows[r].cp)
        `CHK("pass flag", rows[r].ep, o_pass)
      if (rows[r].op > 3'h5 || rows[r].op == `MCS_OP_INIT)
        chk_trace();
      $display("row %0d done", r);
    end
    run(`MCS_OP_START, 0, 0, 0, 3'b000);
    lat = 4'h3;
    fork
      run(`MCS_OP_ADD, 2, 3, 0, 3'b000);
      begin
        repeat (4) @(posedge i_clk);
        i_start <= 1'b1;
        i_op <= `MCS_OP_START;
        @(posedge i_clk);
        i_start <= 1'b0;
      end
    join
    run(`MCS_OP_ADD, 20, 0, 0, 3'b000);
    run(`MCS_OP_ADD, 9, 2, 0, 3'b000);
    run(`MCS_OP_RESULT, 0, 0, 0, 3'b000);
    `CHK("multi-range signature", ~crc_add(crc_add(32'hFFFFFFFF, 2, 3), 9, 2), o_sig)
    $display("multi-range case done");
    lat = 4'h1;
    nd_case(1'b0);
    nd_case(1'b1);
    fault_addr = 6'd49;
    run(`MCS_OP_MARCH, 48, 50, 0, 3'b000);
    `CHK("area fault pass", 1'b0, o_pass)
    $display("area fault case done");
    @(posedge i_clk);
    {i_nondestr, i_buf_check, i_march_x} <= 3'b000;
    i_op <= `MCS_OP_MARCH;
    i_addr_lo <= 32'd48;
    i_addr_hi <= 32'd50;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    repeat (6) @(posedge i_clk);
    #20 i_rst_n = 1'b0;
    #1 `CHK("mid-run reset outputs", 36'h0, {o_busy, o_done, o_pass, o_mem_req, o_sig})
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    run(`MCS_OP_RESULT, 0, 0, 0, 3'b000);
    `CHK("signature after reset", ~32'hFFFFFFFF, o_sig)
    `CHK("result pass after reset", 1'b1, o_pass)
    $display("mid-run reset case done");
    tally_and_finish();
  end
endmodule // mcs_top_bench
`default_nettype wire
